/* File: hdl/drr_router.sv */
`timescale 1ns/10ps
`include "drr_defs.svh"

// What this block does
// R01: each channel keeps a sync overrun flag, cleared by writing one to its clear bit
// R02: sync overrun on one channel survives a clear write aimed at another channel
// R03: each generator keeps a trigger overrun flag, cleared by writing one to its clear bit
// R04: trigger overrun survives a generator clear write aimed at another channel
// R05: each trigger on an idle generator issues request_count plus one requests exactly
// R06: trigger while requests pending, even in the last served cycle, sets overrun
// R07: channel config holds sync enable, 2-bit polarity, 6-bit request, 5-bit sync select
// R08: a newly written request select is routed at once, whatever sync did before; here a held, unserved request keeps the old select until served
// R09: software keeps polarity zero while sync is off, sets it when enabling
// R10: overrun flags stay set until their clear bit is written; zeros do nothing
module drr_router #(
    parameter int NCH  = 4,   // router channels
    parameter int NGEN = 2,   // generator channels
    parameter int NREQ = 64,  // request inputs
    parameter int NSYN = 32   // sync / trigger inputs
) (
    input  wire logic                    i_ref_clk,          // 200 MHz clock
    input  wire logic                    i_sys_rst,          // sync reset, high
    input  wire logic                    i_clk_en,           // freezes state when low
    input  wire logic [NREQ-1:0]         i_req_in,           // peripheral requests, same clock
    input  wire logic [NSYN-1:0]         i_sync_in,          // sync/trigger pins, async
    input  wire drr_pkg::drr_chan_cfg_t  i_chan_cfg [NCH],   // channel config
    input  wire logic [NCH-1:0]          i_chan_cfg_wr,      // channel config write strobes
    input  wire logic [NCH-1:0]          i_sync_overrun_clear,    // one to clear
    input  wire logic                    i_chan_clr_wr,      // clear register write
    input  wire drr_pkg::drr_gen_cfg_t   i_gen_cfg [NGEN],   // generator config
    input  wire logic [NGEN-1:0]         i_trigger_overrun_clear, // one to clear
    input  wire logic                    i_gen_clr_wr,       // gen clear register write
    input  wire logic [NCH-1:0]          i_dma_ack,          // dma served a channel request
    input  wire logic [NGEN-1:0]         i_gen_ack,          // dma served a generator request
    output logic [NCH-1:0]               o_dma_req,          // routed requests
    output logic [NGEN-1:0]              o_gen_req,          // generator requests
    output logic [NCH-1:0]               o_sync_overrun_flag,    // sticky
    output logic [NGEN-1:0]              o_trigger_overrun_flag  // sticky
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NSYN-1:0]     s1;          // first sync stage
        logic [NSYN-1:0]     s2;          // second sync stage
        logic [NSYN-1:0]     s3;          // previous level for edges
        drr_pkg::drr_chan_cfg_t [NCH-1:0] cfg;
        logic [NCH-1:0]      armed;       // sync event seen, pass one request
        logic [NCH-1:0]      req;
        logic [NCH-1:0]      sof;
        logic [NGEN-1:0]     greq;
        logic [NGEN-1:0][5:0] left;       // requests still to issue
        logic [NGEN-1:0]     ovf;
    } drr_state_t;

    drr_state_t st, next_st;

    function automatic logic edge_hit(input logic [1:0] pol, input logic cur, input logic prv);
        unique case (pol)
            `DRR_POL_NONE: edge_hit = 1'b0;
            `DRR_POL_RISE: edge_hit = cur & ~prv;
            `DRR_POL_FALL: edge_hit = ~cur & prv;
            `DRR_POL_BOTH: edge_hit = cur ^ prv;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // the edge detector only reads s2/s3, never the first stage
    always_comb begin
        drr_pkg::drr_chan_cfg_t c;
        drr_pkg::drr_gen_cfg_t  g;
        logic                   ev;
        logic                   clr;
        c       = '0;
        g       = '0;
        ev      = 1'b0;
        clr     = 1'b0;
        next_st = st;
        next_st.s1 = i_sync_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < NCH; i++) begin
            // config taken live; routing takes the new select at once unless a request is still held unserved [R07] [R08]
            if (i_chan_cfg_wr[i]) begin
                next_st.cfg[i] = i_chan_cfg[i];
            end
            c  = next_st.cfg[i];
            ev = c.sync_enable &&
                 edge_hit(c.sync_edge_polarity, st.s2[c.sync_input_select],
                          st.s3[c.sync_input_select]);
            // clear first so that a same-cycle overrun wins [R01] [R02] [R10]
            clr = i_chan_clr_wr && i_sync_overrun_clear[i];
            if (clr) begin
                next_st.sof[i] = 1'b0;
            end
            // sync event while one still armed means overrun
            if (ev && st.armed[i]) begin
                next_st.sof[i] = 1'b1;  // [R02]
            end
            if (ev) begin
                next_st.armed[i] = 1'b1;
            end
            // a served request consumes one armed slot
            if (st.req[i] && i_dma_ack[i]) begin
                next_st.req[i] = 1'b0;
                if (c.sync_enable && !ev) begin
                    next_st.armed[i] = 1'b0;
                end
            end
            // select uses the freshly written value [R08]
            if (!next_st.req[i] || (st.req[i] && i_dma_ack[i])) begin
                next_st.req[i] = i_req_in[c.request_input_select] &&
                                 (!c.sync_enable || next_st.armed[i]);
            end
        end
        for (int j = 0; j < NGEN; j++) begin
            g  = i_gen_cfg[j];
            ev = g.gen_enable &&
                 edge_hit(g.trig_edge_polarity, st.s2[j], st.s3[j]);
            clr = i_gen_clr_wr && i_trigger_overrun_clear[j];
            if (clr) begin
                next_st.ovf[j] = 1'b0;  // [R03] [R10]
            end
            // serve one request
            if (st.greq[j] && i_gen_ack[j]) begin
                next_st.left[j] = st.left[j] - 6'h01;
            end
            // pending includes the final served cycle [R06]
            if (ev && st.left[j] != 6'h00) begin
                next_st.ovf[j] = 1'b1;  // [R04] [R06]
            end else if (ev) begin
                next_st.left[j] = {1'b0, g.request_count} + 6'h01;  // [R05]
            end
            next_st.greq[j] = (next_st.left[j] != 6'h00);
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st <= '0;
        end else if (i_clk_en) begin
            st <= next_st;
        end
    end

    assign o_dma_req              = st.req;
    assign o_gen_req              = st.greq;
    assign o_sync_overrun_flag    = st.sof;
    assign o_trigger_overrun_flag = st.ovf;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // per router channel: a flag moves only by an overrun or its own clear
    for (genvar gi = 0; gi < NCH; gi++) begin : g_chan_chk
        property p_sof_sticky;
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            (st.sof[gi] && i_clk_en && !(i_chan_clr_wr && i_sync_overrun_clear[gi]))
                |=> st.sof[gi];
        endproperty
        a_sof_sticky: assert property (p_sof_sticky) else $error("sync flag lost"); // [R10]

        // nothing armed, so no overrun can race the clear
        property p_sof_clear;
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            (i_clk_en && i_chan_clr_wr && i_sync_overrun_clear[gi] && !st.armed[gi])
                |=> !st.sof[gi];
        endproperty
        a_sof_clear: assert property (p_sof_clear) else $error("sync flag kept"); // [R01]

        // second event while armed flags, whatever clear is being written
        property p_sof_set;
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            (i_clk_en && !i_chan_cfg_wr[gi] && st.armed[gi] && st.cfg[gi].sync_enable &&
             edge_hit(st.cfg[gi].sync_edge_polarity, st.s2[st.cfg[gi].sync_input_select],
                      st.s3[st.cfg[gi].sync_input_select]))
                |=> st.sof[gi];
        endproperty
        a_sof_set: assert property (p_sof_set) else $error("sync overrun missed"); // [R02]
    end

    // per generator: idle trigger loads the count, busy trigger overruns
    for (genvar gj = 0; gj < NGEN; gj++) begin : g_gen_chk
        // count taken as it stood when the trigger was seen
        property p_gen_count;
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            (i_clk_en && st.left[gj] == 6'h00 && i_gen_cfg[gj].gen_enable &&
             edge_hit(i_gen_cfg[gj].trig_edge_polarity, st.s2[gj], st.s3[gj]))
                |=> st.left[gj] == {1'b0, $past(i_gen_cfg[gj].request_count)} + 6'h01;
        endproperty
        a_gen_count: assert property (p_gen_count) else $error("wrong request count"); // [R05]

        // busy includes the cycle in which the last request is served
        property p_gen_ovr;
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            (i_clk_en && st.left[gj] != 6'h00 && i_gen_cfg[gj].gen_enable &&
             edge_hit(i_gen_cfg[gj].trig_edge_polarity, st.s2[gj], st.s3[gj]))
                |=> st.ovf[gj];
        endproperty
        a_gen_ovr: assert property (p_gen_ovr) else $error("overrun missed"); // [R04] [R06]

        property p_ovf_sticky;
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            (st.ovf[gj] && i_clk_en && !(i_gen_clr_wr && i_trigger_overrun_clear[gj]))
                |=> st.ovf[gj];
        endproperty
        a_ovf_sticky: assert property (p_ovf_sticky) else $error("trigger flag lost"); // [R10]

        // an idle generator cannot overrun, so its clear must land
        property p_ovf_clear;
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            (i_clk_en && i_gen_clr_wr && i_trigger_overrun_clear[gj] &&
             st.left[gj] == 6'h00)
                |=> !st.ovf[gj];
        endproperty
        a_ovf_clear: assert property (p_ovf_clear) else $error("trigger flag kept"); // [R03]

        // a request line only drops after the dma served it
        property p_greq_fall;
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            ($fell(o_gen_req[gj]) && !$past(i_sys_rst)) |-> $past(i_gen_ack[gj]);
        endproperty
        a_greq_fall: assert property (p_greq_fall) else $error("request dropped"); // [R05]
    end

endmodule

/* File: shared/drr_defs.svh */
`ifndef DRR_DEFS_SVH
`define DRR_DEFS_SVH
// polarity codes
`define DRR_POL_NONE     2'h0
`define DRR_POL_RISE     2'h1
`define DRR_POL_FALL     2'h2
`define DRR_POL_BOTH     2'h3
// reset values
`define DRR_CFG_RST_SEL  6'h00
`define DRR_CFG_RST_SYN  5'h00
`define DRR_CNT_ZERO     5'h00
`endif

/* File: shared/drr_pkg.sv */
package drr_pkg;
    // per-channel configuration word
    typedef struct packed {
        logic       sync_enable;
        logic [1:0] sync_edge_polarity;
        logic [5:0] request_input_select;
        logic [4:0] sync_input_select;
    } drr_chan_cfg_t;

    // per-generator configuration word
    typedef struct packed {
        logic       gen_enable;
        logic [1:0] trig_edge_polarity;
        logic [4:0] request_count;
    } drr_gen_cfg_t;
endpackage

/* File: sim/drr_dma_model.sv */
`timescale 1ns/10ps

// ------------------------------------------------
// far side: dma channels acking held requests
// ------------------------------------------------
module drr_dma_model #(
    parameter int N = 4  // channels served
) (
    input  wire logic         i_ref_clk, // bench clock
    input  wire logic         i_sys_rst, // sync reset
    input  wire logic         i_slow,    // stretch gap between acks
    input  wire logic [N-1:0] i_req,     // request levels
    output logic      [N-1:0] o_ack      // one-cycle ack pulses
);
    logic [2:0] gap [N];

    // a gap after each ack lets the request line update first
    always @(posedge i_ref_clk) begin
        for (int i = 0; i < N; i++) begin
            if (i_sys_rst) begin
                o_ack[i] <= 1'b0;
                gap[i]   <= 3'h0;
            end else if (o_ack[i]) begin
                o_ack[i] <= 1'b0;
                gap[i]   <= i_slow ? 3'h4 : 3'h1;
            end else if (gap[i] != 3'h0) begin
                gap[i] <= gap[i] - 3'h1;
            end else begin
                o_ack[i] <= i_req[i];
            end
        end
    end
endmodule

/* File: sim/tb.sv */
`timescale 1ns/10ps

module tb;
    logic                   clk = 0, rst = 1, clk_en = 1, slow = 0;
    logic [63:0]            req_in = '0;
    logic [31:0]            sync_in = '0;
    drr_pkg::drr_chan_cfg_t chan_cfg [4];
    drr_pkg::drr_gen_cfg_t  gen_cfg [2];
    logic [3:0]             cfg_wr = '0, sync_clr = '0, dma_req, dma_ack, sync_flag;
    logic [1:0]             trig_clr = '0, gen_req, gen_ack, trig_flag;
    logic                   chan_clr_wr = 0, gen_clr_wr = 0, prev = 0;
    logic [7:0]             acks = '0, n;
    logic [7:0]             exp_q [$];
    int                     miscompares = 0, compares = 0, cycles = 0, k;
    int                     seed = 32'hF300D83B;

    always #2.5 clk = ~clk;

    drr_router DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_req_in(req_in),
        .i_sync_in(sync_in), .i_chan_cfg(chan_cfg), .i_chan_cfg_wr(cfg_wr),
        .i_sync_overrun_clear(sync_clr), .i_chan_clr_wr(chan_clr_wr), .i_gen_cfg(gen_cfg),
        .i_trigger_overrun_clear(trig_clr), .i_gen_clr_wr(gen_clr_wr), .i_dma_ack(dma_ack),
        .i_gen_ack(gen_ack), .o_dma_req(dma_req), .o_gen_req(gen_req),
        .o_sync_overrun_flag(sync_flag), .o_trigger_overrun_flag(trig_flag));
    drr_dma_model #(.N(4)) dma_side (.i_ref_clk(clk), .i_sys_rst(rst), .i_slow(slow),
        .i_req(dma_req), .o_ack(dma_ack));
    drr_dma_model #(.N(2)) gen_side (.i_ref_clk(clk), .i_sys_rst(rst), .i_slow(slow),
        .i_req(gen_req), .o_ack(gen_ack));

    task check(input logic [7:0] seen, input logic [7:0] expv);
        compares++;
        if (seen !== expv) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task results;
        if (miscompares == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task tick(input int c);
        repeat (c) @(posedge clk);
    endtask

    // pin held 4 cycles so the synchroniser always catches it
    task trig(input int pin);
        sync_in[pin] <= 1'b1;
        tick(4);
        sync_in[pin] <= 1'b0;
        tick(4);
    endtask

    task wait_idle;
        k = 0;
        while (gen_req !== 2'h0 && k < 400) begin
            tick(1);
            k++;
        end
        // a burst that never ends is a failure
        if (gen_req !== 2'h0) miscompares++;
    endtask

    // watcher: acks per generator 0 burst against the oldest note
    always @(posedge clk) begin
        if (gen_req[0] && gen_ack[0]) acks++;
        if (prev && !gen_req[0]) begin
            check(acks, exp_q.size() ? exp_q.pop_front() : 8'hFF);
            acks = 8'h00;
        end
        prev = gen_req[0];
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results;
        end
    end

    initial begin
        chan_cfg = '{default: '0};
        gen_cfg  = '{'{1'b1, 2'h1, 5'h01}, '{1'b1, 2'h1, 5'h03}};
        tick(20);
        rst <= 1'b0;
        tick(2);
        for (int i = 0; i < 6; i++) begin
            n = (i == 0) ? 8'h01 : ($random(seed) & 8'h07);
            gen_cfg[0].request_count <= n[4:0];
            exp_q.push_back(n + 8'h01);
            tick(1);
            trig(0);
            wait_idle;
        end
        slow <= 1'b1;
        gen_cfg[0].request_count <= 5'h03;
        exp_q.push_back(8'h04);
        trig(0);
        trig(0);
        wait_idle;
        check({6'h0, trig_flag}, 8'h01);
        // overrun on gen 1 while a clear for gen 0 is held
        trig(1);
        gen_clr_wr <= 1'b1;
        trig_clr <= 2'h1;
        trig(1);
        gen_clr_wr <= 1'b0;
        trig_clr <= 2'h0;
        wait_idle;
        check({6'h0, trig_flag}, 8'h02);
        gen_clr_wr <= 1'b1;
        tick(1);
        gen_clr_wr <= 1'b0;
        tick(2);
        check({6'h0, trig_flag}, 8'h02);
        gen_clr_wr <= 1'b1;
        trig_clr <= 2'h2;
        tick(1);
        gen_clr_wr <= 1'b0;
        tick(2);
        check({6'h0, trig_flag}, 8'h00);
        slow <= 1'b0;
        // second trigger lands in the cycle the only request is served
        gen_cfg[0].request_count <= 5'h00;
        exp_q.push_back(8'h01);
        tick(1);
        sync_in[0] <= 1'b1;
        tick(1);
        sync_in[0] <= 1'b0;
        tick(1);
        trig(0);
        wait_idle;
        check({6'h0, trig_flag}, 8'h01);
        // the next trigger still issues the full count
        gen_cfg[0].request_count <= 5'h02;
        exp_q.push_back(8'h03);
        tick(1);
        trig(0);
        wait_idle;
        // reselect after a sync event two cycles earlier
        req_in[5] <= 1'b1;
        sync_in[3] <= 1'b1;
        tick(2);
        chan_cfg[0] <= '{1'b0, 2'h0, 6'h05, 5'h03};
        cfg_wr <= 4'h1;
        tick(1);
        cfg_wr <= 4'h0;
        sync_in[3] <= 1'b0;
        // routed in the cycle right after the write, not later
        tick(1);
        check({7'h0, dma_req[0]}, 8'h01);
        req_in[5] <= 1'b0;
        chan_cfg[1] <= '{1'b1, 2'h1, 6'h0A, 5'h04};
        cfg_wr <= 4'h2;
        tick(1);
        cfg_wr <= 4'h0;
        chan_clr_wr <= 1'b1;
        sync_clr <= 4'h1;
        trig(4);
        trig(4);
        chan_clr_wr <= 1'b0;
        sync_clr <= 4'h0;
        tick(2);
        check({4'h0, sync_flag}, 8'h02);
        chan_clr_wr <= 1'b1;
        sync_clr <= 4'h2;
        tick(1);
        chan_clr_wr <= 1'b0;
        tick(2);
        check({4'h0, sync_flag}, 8'h00);
        check(8'(exp_q.size()), 8'h00);
        results;
    end
endmodule
